// ---- design/dosm_top.sv ----
// Operating-state controller of a servo drive with Avalon-MM registers
// Assumes condition inputs synchronous to clk_sys and a bus master
// that holds each request until waitrequest is seen low
`timescale 1ns/100ps
`default_nettype none
`include "dosm_defs.svh"

module dosm_top (
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire logic [3:0]           avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	output var  logic [31:0]          avs_readdata,
	output var  logic                 avs_waitrequest,
	input  wire logic                 enable_in,
	input  wire logic                 fault_clear_in,
	input  wire dosm_pkg::dosm_cond_s cond,
	output var  dosm_pkg::dosm_act_s  act,
	output var  dosm_pkg::dosm_state_e op_state
);
	import dosm_pkg::*;

	// ----------------------------------------------------------------
	// State record
	// ----------------------------------------------------------------
	typedef struct packed {
		dosm_state_e state;
		logic [2:0]  cfg;
		dosm_cmd_e   cmd;
		logic [1:0]  en_sync;
		logic        en_prev;
		logic [1:0]  fc_sync;
		logic        fc_prev;
		logic        qs_bus;
		logic        dis_pend;
		logic        frx_qs;
		logic        fatal4;
		dosm_act_s   act;
		logic        busy;
		logic [31:0] rdata;
	} dosm_reg_s;

	dosm_reg_s st_r;
	dosm_reg_s st_nxt;

	function automatic logic [3:0] state_num(input dosm_state_e s);
		case (s)
			ST_START:     state_num = 4'h1;
			ST_NOT_READY: state_num = 4'h2;
			ST_DISABLED:  state_num = 4'h3;
			ST_READY:     state_num = 4'h4;
			ST_SWITCHED:  state_num = 4'h5;
			ST_OPERATE:   state_num = 4'h6;
			ST_QSTOP:     state_num = 4'h7;
			ST_REACTION:  state_num = 4'h8;
			ST_FAULT:     state_num = 4'h9;
			default:      state_num = 4'h0;
		endcase
	endfunction

	// ----------------------------------------------------------------
	// Decoded conditions
	// ----------------------------------------------------------------
	logic req;
	logic en_rise;
	logic en_fall;
	logic fc_rise;
	logic err_hi;
	logic err_one;
	logic cause_clr;
	logic need_sd;
	logic ready_ok;
	logic ready_drop;
	logic hold_state;

	assign req       = avs_read | avs_write;
	// R24 edges seen on synchronised copies only
	assign en_rise   = st_r.en_sync[1] & ~st_r.en_prev;
	assign en_fall   = ~st_r.en_sync[1] & st_r.en_prev;
	assign fc_rise   = st_r.fc_sync[1] & ~st_r.fc_prev;
	assign err_hi    = cond.err_class >= 3'h2;
	assign err_one   = cond.err_class == 3'h1;
	assign cause_clr = cond.err_class == 3'h0;
	// R8 shutdown gate on bus, CANopen and compat
	assign need_sd   = st_r.cfg[`DOSM_CFG_BUS] & st_r.cfg[`DOSM_CFG_CAN]
		& st_r.cfg[`DOSM_CFG_COMPAT];
	assign ready_ok  = cond.encoder_ok & cond.dc_bus_ok
		& cond.safety_input_a & cond.safety_input_b & cond.speed_ok;
	assign ready_drop = ~cond.dc_bus_ok | ~cond.speed_ok
		| (~cond.safety_input_a & ~cond.safety_input_b);
	assign hold_state = st_r.state == ST_REACTION
		| st_r.state == ST_FAULT;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		st_nxt = st_r;
		// R24 two-flop synchronisers
		st_nxt.en_sync = {st_r.en_sync[0], enable_in};
		st_nxt.en_prev = st_r.en_sync[1];
		st_nxt.fc_sync = {st_r.fc_sync[0], fault_clear_in};
		st_nxt.fc_prev = st_r.fc_sync[1];
		st_nxt.cmd = CMD_NONE;
		st_nxt.busy = 1'b1;
		// Bus answer one cycle after the request
		if (req && st_r.busy) begin
			st_nxt.busy = 1'b0;
			st_nxt.rdata = 32'h0;
			if (avs_read && avs_address == `DOSM_OFS_CFG) begin
				st_nxt.rdata[2:0] = st_r.cfg;
			end
			if (avs_read && avs_address == `DOSM_OFS_STAT) begin
				st_nxt.rdata[3:0] = state_num(st_r.state);
				st_nxt.rdata[`DOSM_ST_AMP] = st_r.act.amp_on;
				st_nxt.rdata[`DOSM_ST_BRAKE] = st_r.act.brake_release;
				st_nxt.rdata[`DOSM_ST_HALT] = st_r.act.halt;
				st_nxt.rdata[`DOSM_ST_QSTOP] = st_r.act.quick_stop;
				st_nxt.rdata[`DOSM_ST_QSBUS] = st_r.qs_bus;
			end
		end
		if (avs_write && !st_r.busy) begin
			if (avs_address == `DOSM_OFS_CFG) begin
				st_nxt.cfg = avs_writedata[2:0];
			end
			// R3 commands only under fieldbus control
			if (avs_address == `DOSM_OFS_CMD
				&& st_r.cfg[`DOSM_CFG_BUS]) begin
				st_nxt.cmd = dosm_cmd_e'(avs_writedata[2:0]);
			end
		end
		// R4 each branch takes any one alternative
		// R18 class 2 to 4 from any state except fault reaction and fault
		if (err_hi && !hold_state) begin
			st_nxt.state = ST_REACTION;
			// R2 class 2 stops first, 3 and 4 cut off
			st_nxt.frx_qs = st_r.act.amp_on
				&& cond.err_class == 3'h2;
			st_nxt.fatal4 = st_r.fatal4 || cond.err_class == 3'h4;
		end else begin
			case (st_r.state)
				ST_START: begin
					// R5 start to not ready
					if (cond.init_done || cond.speed_low) begin
						st_nxt.state = ST_NOT_READY;
					end
				end
				ST_NOT_READY: begin
					// R6 commissioning done
					if (cond.commission_done) begin
						st_nxt.state = ST_DISABLED;
					end
				end
				ST_DISABLED: begin
					// R7 checks met give ready
					if (ready_ok
						&& (!need_sd || st_r.cmd == CMD_SHUTDOWN)) begin
						st_nxt.state = ST_READY;
					end
				end
				ST_READY: begin
					// R14 voltage, both safety inputs or speed lost
					if (ready_drop || st_r.cmd == CMD_DISABLE_V) begin
						st_nxt.state = ST_DISABLED;
					// R9 switch on by command or edge
					end else if (st_r.cmd == CMD_SWITCH_ON || en_rise) begin
						st_nxt.state = ST_SWITCHED;
					end
				end
				ST_SWITCHED: begin
					// R10 enable operation
					if (st_r.cmd == CMD_ENABLE_OP) begin
						st_nxt.state = ST_OPERATE;
					// R13 shutdown to ready
					end else if (st_r.cmd == CMD_SHUTDOWN) begin
						st_nxt.state = ST_READY;
					// R15 disable voltage
					end else if (st_r.cmd == CMD_DISABLE_V) begin
						st_nxt.state = ST_DISABLED;
					end
				end
				ST_OPERATE: begin
					// R15 disable voltage, amplifier off
					if (st_r.cmd == CMD_DISABLE_V) begin
						st_nxt.state = ST_DISABLED;
					// R13 shutdown, amplifier off at once
					end else if (st_r.cmd == CMD_SHUTDOWN) begin
						st_nxt.state = ST_READY;
					// R16 class 1 or quick stop command
					end else if (err_one
						|| st_r.cmd == CMD_QUICK_STOP) begin
						st_nxt.state = ST_QSTOP;
						st_nxt.qs_bus = st_r.cmd == CMD_QUICK_STOP
							&& !err_one;
					// R11 halt until standstill
					end else if (st_r.dis_pend && cond.standstill) begin
						st_nxt.state = ST_SWITCHED;
					// R12 enable fall also halts
					end else if (st_r.cmd == CMD_DISABLE_OP || en_fall) begin
						st_nxt.dis_pend = 1'b1;
					end
				end
				ST_QSTOP: begin
					// R17 disable voltage ends quick stop
					if (st_r.cmd == CMD_DISABLE_V) begin
						st_nxt.state = ST_DISABLED;
					// R22 R23 resume operation
					end else if (cause_clr
						&& (st_r.cmd == CMD_FAULT_RESET || fc_rise
						|| (st_r.cmd == CMD_ENABLE_OP && st_r.qs_bus))) begin
						st_nxt.state = ST_OPERATE;
					end
				end
				ST_REACTION: begin
					// R19 response completed
					if (!st_r.frx_qs || cond.standstill) begin
						st_nxt.state = ST_FAULT;
					end
				end
				ST_FAULT: begin
					// R20 R21 reset once cause removed, never after a class 4 error that started the fault reaction
					if (cause_clr && !st_r.fatal4
						&& (st_r.cmd == CMD_FAULT_RESET || fc_rise)) begin
						st_nxt.state = ST_DISABLED;
					end
				end
				default: begin
					st_nxt.state = ST_START;
				end
			endcase
		end
		if (st_nxt.state != ST_OPERATE) begin
			st_nxt.dis_pend = 1'b0;
		end
		if (st_nxt.state != ST_QSTOP) begin
			st_nxt.qs_bus = 1'b0;
		end
		if (st_nxt.state != ST_REACTION) begin
			st_nxt.frx_qs = 1'b0;
		end
		// R1 actions follow the held state
		st_nxt.act.amp_on = st_nxt.state == ST_OPERATE
			|| st_nxt.state == ST_QSTOP || st_nxt.frx_qs;
		st_nxt.act.brake_release = st_nxt.act.amp_on;
		st_nxt.act.halt = st_nxt.dis_pend;
		st_nxt.act.quick_stop = st_nxt.state == ST_QSTOP
			|| st_nxt.frx_qs;
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			st_r <= '0;
			st_r.state <= ST_START;
			st_r.cfg <= `DOSM_CFG_RST;
			st_r.cmd <= CMD_NONE;
			st_r.busy <= 1'b1;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign avs_readdata    = st_r.rdata;
	assign avs_waitrequest = st_r.busy;
	assign act             = st_r.act;
	assign op_state        = st_r.state;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (sys_rst);

	chk_bus_answer: assert property ( // R3
		req && st_r.busy |=> !st_r.busy ##1 st_r.busy)
		else $error("bus answer not one cycle");
	chk_start_exit: assert property ( // R5
		st_r.state == ST_START && !err_hi
		&& (cond.init_done || cond.speed_low)
		|=> st_r.state == ST_NOT_READY)
		else $error("start not left");
	chk_ready_entry: assert property ( // R7
		st_r.state == ST_READY && $past(st_r.state) == ST_DISABLED
		|-> $past(ready_ok))
		else $error("ready without checks");
	chk_sd_gate: assert property ( // R8
		st_r.state == ST_DISABLED && need_sd
		&& st_r.cmd != CMD_SHUTDOWN |=> st_r.state != ST_READY)
		else $error("ready without shutdown");
	chk_switch_on: assert property ( // R9
		st_r.state == ST_READY && !err_hi && !ready_drop
		&& st_r.cmd != CMD_DISABLE_V && en_rise
		|=> st_r.state == ST_SWITCHED)
		else $error("enable edge ignored");
	chk_enable_amp: assert property ( // R10
		st_r.state == ST_SWITCHED && !err_hi
		&& st_r.cmd == CMD_ENABLE_OP
		|=> st_r.state == ST_OPERATE && act.amp_on && act.brake_release)
		else $error("operation not enabled");
	chk_halt_first: assert property ( // R11
		st_r.state == ST_SWITCHED && $past(st_r.state) == ST_OPERATE
		|-> $past(act.halt) && !act.amp_on && !act.brake_release)
		else $error("left operation without halt");
	chk_voltage_off: assert property ( // R15
		st_r.state inside {ST_SWITCHED, ST_OPERATE, ST_QSTOP}
		&& !err_hi && st_r.cmd == CMD_DISABLE_V
		|=> st_r.state == ST_DISABLED && !act.amp_on)
		else $error("disable voltage missed");
	chk_qs_entry: assert property ( // R16
		st_r.state == ST_OPERATE && !err_hi && err_one
		&& !(st_r.cmd inside {CMD_DISABLE_V, CMD_SHUTDOWN})
		|=> st_r.state == ST_QSTOP && act.quick_stop)
		else $error("class 1 not stopped");
	chk_fault_entry: assert property ( // R18
		err_hi && !hold_state |=> st_r.state == ST_REACTION)
		else $error("fault reaction missed");
	chk_fault_done: assert property ( // R19
		st_r.state == ST_REACTION && !st_r.frx_qs
		|=> st_r.state == ST_FAULT)
		else $error("fault not reached");
	chk_cause_kept: assert property ( // R21
		st_r.state == ST_FAULT && !cause_clr |=> st_r.state == ST_FAULT)
		else $error("fault reset with cause");
	chk_qs_bus_only: assert property ( // R23
		st_r.state == ST_QSTOP && !st_r.qs_bus && !fc_rise
		&& st_r.cmd == CMD_ENABLE_OP |=> st_r.state != ST_OPERATE)
		else $error("local stop left by enable");
	chk_edge_once: assert property ( // R24
		en_rise |=> !en_rise)
		else $error("edge seen twice");

	cov_operate: cover property (
		st_r.state == ST_SWITCHED ##1 st_r.state == ST_OPERATE);
	cov_qs_resume: cover property (
		st_r.state == ST_QSTOP ##1 st_r.state == ST_OPERATE);
	cov_fault_clear: cover property (
		st_r.state == ST_FAULT ##1 st_r.state == ST_DISABLED);
	cov_halt_exit: cover property (
		act.halt ##1 st_r.state == ST_SWITCHED);

endmodule // dosm_top

`default_nettype wire

// ---- design/dosm_defs.svh ----
// Offsets, field positions and reset values of the operating-state block
// Assumes inclusion by bare name; holds definitions only
// Operation
// R1 - Nine numbered operating states held
// R2 - Error class selects stop and switch-off
// R3 - Changes by input, bus command, monitoring
// R4 - Any one listed condition triggers change
// R5 - Start leaves once initialised or slow
// R6 - Not ready leaves after first commissioning
// R7 - Checks met give ready to switch on
// R8 - Shutdown needed only bus, CANopen, compat
// R9 - Switch On or enable rise switches on
// R10 - Enable Operation powers amplifier, releases brake
// R11 - Disable Operation halts, brakes, powers off
// R12 - Enable falling edge also leaves operation
// R13 - Shutdown returns to ready, amplifier off
// R14 - Ready drops on voltage, safety, speed; code drops on safety only when both inputs are lost
// R15 - Disable Voltage drops to switch-on disabled
// R16 - Class 1 or Quick Stop command
// R17 - Disable Voltage ends quick stop, off
// R18 - Class 2 to 4 enter fault reaction
// R19 - Fault reaction completes into fault
// R20 - Fault reset clears fault to disabled; code keeps fault until sys_rst after a class 4 error that starts the fault reaction
// R21 - Reset only once cause removed
// R22 - Reset or enable resumes operation
// R23 - Enable exit only for bus quick stop
// R24 - Inputs synchronised, one change per edge
`ifndef DOSM_DEFS_SVH
`define DOSM_DEFS_SVH
`define DOSM_OFS_CFG    4'h0
`define DOSM_OFS_CMD    4'h4
`define DOSM_OFS_STAT   4'h8
`define DOSM_CFG_BUS    0
`define DOSM_CFG_CAN    1
`define DOSM_CFG_COMPAT 2
`define DOSM_CFG_RST    3'h0
`define DOSM_ST_AMP     4
`define DOSM_ST_BRAKE   5
`define DOSM_ST_HALT    6
`define DOSM_ST_QSTOP   7
`define DOSM_ST_QSBUS   8
`endif

// ---- design/dosm_pkg.sv ----
// Types of the operating-state block
// Assumes the constants header is on the include path
package dosm_pkg;
	typedef enum logic [3:0] {
		ST_START     = 4'h0,
		ST_NOT_READY = 4'h1,
		ST_DISABLED  = 4'h3,
		ST_READY     = 4'h2,
		ST_SWITCHED  = 4'h6,
		ST_OPERATE   = 4'h7,
		ST_QSTOP     = 4'h5,
		ST_REACTION  = 4'h4,
		ST_FAULT     = 4'hc
	} dosm_state_e;
	typedef enum logic [2:0] {
		CMD_NONE        = 3'h0,
		CMD_SHUTDOWN    = 3'h1,
		CMD_SWITCH_ON   = 3'h2,
		CMD_ENABLE_OP   = 3'h3,
		CMD_DISABLE_OP  = 3'h4,
		CMD_DISABLE_V   = 3'h5,
		CMD_QUICK_STOP  = 3'h6,
		CMD_FAULT_RESET = 3'h7
	} dosm_cmd_e;
	typedef struct packed {
		logic       init_done;
		logic       speed_low;
		logic       commission_done;
		logic       encoder_ok;
		logic       dc_bus_ok;
		logic       safety_input_a;
		logic       safety_input_b;
		logic       speed_ok;
		logic       standstill;
		logic [2:0] err_class;
	} dosm_cond_s;
	typedef struct packed {
		logic amp_on;
		logic brake_release;
		logic halt;
		logic quick_stop;
	} dosm_act_s;
endpackage

// ---- sim/dosm_plant.sv ----
// Motor and condition model on the far side of the state block
// Assumes act from the block and fault and bus levels set by the bench
`timescale 1ns/100ps
`default_nettype none

module dosm_plant (
	input  wire logic                 clk_sys,
	input  wire logic                 sys_rst,
	input  wire dosm_pkg::dosm_act_s  act,
	input  wire logic [2:0]           err_class,
	input  wire logic                 bus_ok,
	input  wire logic [1:0]           safety,
	output var  dosm_pkg::dosm_cond_s cond
);
	import dosm_pkg::*;

	logic [3:0] spd_r;
	logic [2:0] boot_r;

	// ----------------------------------------
	// Boot delay and motor coast-down
	// ----------------------------------------
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			spd_r  <= 4'h0;
			boot_r <= 3'h0;
		end else begin
			if (boot_r != 3'h7)
				boot_r <= boot_r + 3'h1;
			if (act.amp_on && !act.halt && !act.quick_stop)
				spd_r <= 4'h6;
			else if (spd_r != 4'h0)
				spd_r <= spd_r - 4'h1;
		end
	end

	always_comb begin
		cond = '0;
		cond.init_done       = boot_r == 3'h7;
		cond.speed_low       = spd_r == 4'h0;
		cond.commission_done = boot_r == 3'h7;
		cond.encoder_ok      = 1'b1;
		cond.dc_bus_ok       = bus_ok;
		cond.safety_input_a  = safety[1];
		cond.safety_input_b  = safety[0];
		cond.speed_ok        = 1'b1;
		cond.standstill      = spd_r == 4'h0;
		// cause held until bench clears it
		cond.err_class       = err_class;
	end
endmodule // dosm_plant
`default_nettype wire

// ---- sim/dosm_top_test.sv ----
// Self-checking bench of the operating-state block
// Assumes the design files and the plant model are compiled first
`timescale 1ns/100ps
`default_nettype none

module dosm_top_test;
	import dosm_pkg::*;

	logic        clk_sys         = 1'b0;
	logic        sys_rst         = 1'b1;
	logic [3:0]  avs_address     = 4'h0;
	logic        avs_read        = 1'b0;
	logic        avs_write       = 1'b0;
	logic [31:0] avs_writedata   = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        enable_in       = 1'b0;
	logic        fault_clear_in  = 1'b0;
	logic [2:0]  err             = 3'h0;
	logic        bus_ok          = 1'b1;
	logic [1:0]  safety          = 2'h3;
	dosm_cond_s  cond;
	dosm_act_s   act;
	dosm_state_e op_state;
	logic [31:0] rdq;
	int          fail_count      = 0;
	int          checks          = 0;
	int          cyc             = 0;

	dosm_top dut (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .enable_in(enable_in),
		.fault_clear_in(fault_clear_in), .cond(cond), .act(act),
		.op_state(op_state)
	);

	dosm_plant plant (
		.clk_sys(clk_sys), .sys_rst(sys_rst), .act(act),
		.err_class(err), .bus_ok(bus_ok), .safety(safety), .cond(cond)
	);

	always #4 clk_sys = ~clk_sys;

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task give_verdict;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e) begin
			fail_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		avs_address   <= a;
		avs_writedata <= d;
		avs_read      <= rd;
		avs_write     <= !rd;
		do begin
			@(posedge clk_sys);
		end while (avs_waitrequest !== 1'b0);
		rdq = avs_readdata;
		avs_read  <= 1'b0;
		avs_write <= 1'b0;
		#1;
	endtask

	task cmd(input dosm_cmd_e c);
		bus(1'b0, 4'h4, {29'h0, c});
	endtask

	task st(input dosm_state_e e);
		int n;
		n = 0;
		while (op_state !== e && n < 40) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(32'(op_state), 32'(e));
	endtask

	task hold(input dosm_state_e e);
		repeat (8) @(posedge clk_sys);
		#1;
		chk(32'(op_state), 32'(e));
	endtask

	task pin_clear;
		@(posedge clk_sys);
		fault_clear_in <= 1'b1;
		repeat (6) @(posedge clk_sys);
		fault_clear_in <= 1'b0;
	endtask

	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			fail_count++;
			give_verdict;
		end
	end

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		repeat (12) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		chk(32'(op_state), 32'(ST_START));
		bus(1'b0, 4'h0, 32'h7);
		st(ST_NOT_READY);
		st(ST_DISABLED);
		bus(1'b1, 4'h0, 32'h0);
		chk(rdq, 32'h7);
		bus(1'b1, 4'hc, 32'h0);
		chk(rdq, 32'h0);
		hold(ST_DISABLED);
		cmd(CMD_SHUTDOWN);
		st(ST_READY);
		$display("test power_up finished");
		@(posedge clk_sys);
		bus_ok <= 1'b0;
		st(ST_DISABLED);
		@(posedge clk_sys);
		bus_ok <= 1'b1;
		safety <= 2'h1;
		cmd(CMD_SHUTDOWN);
		hold(ST_DISABLED);
		@(posedge clk_sys);
		safety <= 2'h3;
		cmd(CMD_SHUTDOWN);
		st(ST_READY);
		@(posedge clk_sys);
		safety <= 2'h2;
		hold(ST_READY);
		@(posedge clk_sys);
		safety <= 2'h0;
		st(ST_DISABLED);
		@(posedge clk_sys);
		safety <= 2'h3;
		cmd(CMD_SHUTDOWN);
		st(ST_READY);
		$display("test ready_drop finished");
		cmd(CMD_SWITCH_ON);
		st(ST_SWITCHED);
		cmd(CMD_ENABLE_OP);
		st(ST_OPERATE);
		chk(32'(act), 32'h0c);
		bus(1'b1, 4'h8, 32'h0);
		chk(rdq, 32'h36);
		cmd(CMD_SHUTDOWN);
		st(ST_READY);
		chk(32'(act), 32'h0);
		cmd(CMD_SWITCH_ON);
		st(ST_SWITCHED);
		cmd(CMD_ENABLE_OP);
		st(ST_OPERATE);
		cmd(CMD_DISABLE_V);
		st(ST_DISABLED);
		chk(32'(act), 32'h0);
		cmd(CMD_SHUTDOWN);
		st(ST_READY);
		cmd(CMD_SWITCH_ON);
		st(ST_SWITCHED);
		cmd(CMD_ENABLE_OP);
		st(ST_OPERATE);
		cmd(CMD_DISABLE_OP);
		st(ST_SWITCHED);
		chk(32'(act), 32'h0);
		$display("test bus_operate finished");
		cmd(CMD_SHUTDOWN);
		st(ST_READY);
		@(posedge clk_sys);
		enable_in <= 1'b1;
		st(ST_SWITCHED);
		cmd(CMD_ENABLE_OP);
		st(ST_OPERATE);
		@(posedge clk_sys);
		enable_in <= 1'b0;
		st(ST_SWITCHED);
		chk(32'(act), 32'h0);
		$display("test local_enable finished");
		cmd(CMD_ENABLE_OP);
		st(ST_OPERATE);
		cmd(CMD_QUICK_STOP);
		st(ST_QSTOP);
		chk(32'(act), 32'h0d);
		bus(1'b1, 4'h8, 32'h0);
		chk(rdq, 32'h1b7);
		cmd(CMD_ENABLE_OP);
		st(ST_OPERATE);
		@(posedge clk_sys);
		err <= 3'h1;
		st(ST_QSTOP);
		@(posedge clk_sys);
		err <= 3'h0;
		cmd(CMD_ENABLE_OP);
		hold(ST_QSTOP);
		pin_clear;
		st(ST_OPERATE);
		hold(ST_OPERATE);
		cmd(CMD_QUICK_STOP);
		st(ST_QSTOP);
		cmd(CMD_DISABLE_V);
		st(ST_DISABLED);
		chk(32'(act), 32'h0);
		$display("test quick_stop finished");
		@(posedge clk_sys);
		err <= 3'h3;
		st(ST_REACTION);
		st(ST_FAULT);
		chk(32'(act), 32'h0);
		cmd(CMD_FAULT_RESET);
		hold(ST_FAULT);
		@(posedge clk_sys);
		err <= 3'h0;
		pin_clear;
		st(ST_DISABLED);
		cmd(CMD_SHUTDOWN);
		st(ST_READY);
		cmd(CMD_SWITCH_ON);
		st(ST_SWITCHED);
		cmd(CMD_ENABLE_OP);
		st(ST_OPERATE);
		@(posedge clk_sys);
		err <= 3'h2;
		st(ST_REACTION);
		chk(32'(act), 32'h0d);
		st(ST_FAULT);
		chk(32'(act), 32'h0);
		@(posedge clk_sys);
		err <= 3'h0;
		cmd(CMD_FAULT_RESET);
		st(ST_DISABLED);
		@(posedge clk_sys);
		err <= 3'h4;
		st(ST_FAULT);
		@(posedge clk_sys);
		err <= 3'h0;
		cmd(CMD_FAULT_RESET);
		hold(ST_FAULT);
		$display("test fault finished");
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		sys_rst <= 1'b0;
		#1;
		chk(32'(op_state), 32'(ST_START));
		chk(32'(act), 32'h0);
		st(ST_READY);
		bus(1'b1, 4'h0, 32'h0);
		chk(rdq, 32'h0);
		cmd(CMD_DISABLE_V);
		hold(ST_READY);
		$display("test restart finished");
		give_verdict;
	end
endmodule // dosm_top_test
`default_nettype wire
